// ### card_socket_irq_map.svh
// register map, field positions, reset values for the socket interrupt event block
// assumes: included by bare name from the design file
`ifndef CARD_SOCKET_IRQ_MAP_SVH
`define CARD_SOCKET_IRQ_MAP_SVH

// -----------------------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------------------
`define CHANGE_FLAGS_OFFSET     8'h04
`define CHANGE_MASKS_OFFSET     8'h05
`define CARD_CONTROL_OFFSET     8'h91

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define FLAG_BATTERY_ONE_BIT    0
`define FLAG_BATTERY_TWO_BIT    1
`define FLAG_READY_BIT          2
`define FLAG_POWER_DONE_BIT     3
`define FLAG_DETECT_BIT         4
`define CTL_FUNC_FLAG_BIT       0
`define CTL_SPARE_BIT           7
`define SOCK_STATUS_BIT         0
`define SOCK_DETECT_ONE_BIT     1
`define SOCK_DETECT_TWO_BIT     2
`define SOCK_POWER_DONE_BIT     3

// -----------------------------------------------------------------------------
// reset values and widths
// -----------------------------------------------------------------------------
`define LEGACY_FLAG_WIDTH       5
`define CHANGE_FLAGS_RESET      5'h00
`define CHANGE_MASKS_RESET      8'h00
`define SOCK_EVENT_RESET        4'h0
`define READ_DATA_RESET         8'h00
`define TERMINAL_COUNT          7

`endif

// ### card_socket_irq_pkg.sv
// types shared by the socket interrupt event block
// assumes: the map header is compiled alongside
package card_socket_irq_pkg;

	// -------------------------------------------------------------------------
	// card type reported by the socket interrogation logic
	// -------------------------------------------------------------------------
	typedef enum logic [1:0] {
		CARD_NONE,
		CARD_MEM16,
		CARD_IO16,
		CARD_CARDBUS
	} card_type_type;

	// -------------------------------------------------------------------------
	// signalling scheme for terminals 1..6
	// -------------------------------------------------------------------------
	typedef enum logic {
		SCHEME_PARALLEL,
		SCHEME_SERIAL
	} irq_scheme_type;

endpackage : card_socket_irq_pkg

// ### card_socket_interrupt_events.sv
// socket interrupt event detection, flags, masks and terminal routing
// assumes: socket pins and card type are synchronous to clk_in; the register
// port is a simple strobe port sampled on clk_in; serial framing happens outside
//
// Behaviour
// - status-change and functional sources handled separately
// - memory card: battery pin edges flag bits 1,0
// - memory card: ready pin edge flags bit 2
// - io card: status-change assertion flags bit 0
// - io card: irq pin sets 91h bit 0
// - cardbus: status-change assertion sets socket event 0
// - cardbus: irq pin sets 91h bit 0
// - power-up done sets bit 3, masked
// - card-detect edges set socket events 2,1
// - insertion/removal seen for any card type
// - no functional interrupts for memory cards
// - shared pins interpreted by card type
// - all signalling through seven multifunction terminals
// - parallel pci with parallel or serial irq
// - legacy flags cleared on read or write-one
// - socket event cleared by writing one
`timescale 1ns/100ps
`include "card_socket_irq_map.svh"

module card_socket_interrupt_events (
	// clock and reset
	input  wire                                 clk_in,
	input  wire                                 rst_in,
	// socket pins and card state
	input  card_socket_irq_pkg::card_type_type  card_type_in,
	input  wire                                 battery_detect_one_in,
	input  wire                                 battery_detect_two_in,
	input  wire                                 ready_pin_in,
	input  wire                                 card_detect_one_in,
	input  wire                                 card_detect_two_in,
	input  wire                                 power_up_done_in,
	// register port
	input  wire  [7:0]                          reg_addr_in,
	input  wire                                 reg_write_in,
	input  wire                                 reg_read_in,
	input  wire  [7:0]                          reg_wdata_in,
	output logic [7:0]                          reg_rdata_out,
	// socket register bits and global control
	input  wire  [3:0]                          socket_mask_in,
	input  wire  [3:0]                          socket_event_clear_in,
	output logic [3:0]                          socket_event_out,
	input  wire                                 flag_clear_method_in,
	// terminal routing
	input  wire                                 pci_intr_enable_in,
	input  card_socket_irq_pkg::irq_scheme_type irq_scheme_in,
	input  wire  [2:0]                          csc_route_in,
	input  wire  [2:0]                          func_route_in,
	// multifunction terminals and status-change event
	output logic [6:0]                          multifunction_outputs_out,
	output logic [6:0]                          multifunction_oe_out,
	output logic                                status_change_event_out
);

	// -------------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------------
	logic [4:0] flags_reg, flags_next;
	logic [7:0] masks_reg, masks_next;
	logic       ctl_spare_reg, ctl_spare_next;
	logic       func_flag_reg, func_flag_next;
	logic [3:0] sock_event_reg, sock_event_next;
	logic [4:0] pin_prev_reg, pin_prev_next;
	logic       primed_reg, primed_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [6:0] mf_out_reg, mf_out_next;
	logic [6:0] mf_oe_reg, mf_oe_next;
	logic       csc_reg, csc_next;

	// -------------------------------------------------------------------------
	// pin interpretation
	// -------------------------------------------------------------------------
	logic       is_mem, is_io, is_cb;
	logic [4:0] pins_now, pin_edge;
	logic       card_status_change_pin, cb_status_change_pin;
	logic       io_card_irq_pin, cb_irq_pin;
	logic       detect_edge;
	logic [4:0] flag_set;
	logic [3:0] sock_set;
	logic       csc_req, func_req;

	function automatic logic [6:0] route_onehot(input logic [2:0] sel, input logic req);
		route_onehot = 7'h00;
		if (sel != 3'h0 && sel < 3'h7) begin
			route_onehot[sel] = req;
		end
	endfunction : route_onehot

	// one shared pin has three meanings; card type picks which applies
	assign is_mem = (card_type_in == card_socket_irq_pkg::CARD_MEM16);
	assign is_io  = (card_type_in == card_socket_irq_pkg::CARD_IO16);
	assign is_cb  = (card_type_in == card_socket_irq_pkg::CARD_CARDBUS);
	assign card_status_change_pin = is_io & ~battery_detect_one_in;     // active low on io cards
	assign cb_status_change_pin   = is_cb &  battery_detect_one_in;     // active high on cardbus
	assign io_card_irq_pin        = is_io & ~ready_pin_in;
	assign cb_irq_pin             = is_cb & ~ready_pin_in;
	assign pins_now = {card_detect_two_in, card_detect_one_in, ready_pin_in,
		battery_detect_two_in, battery_detect_one_in};
	// the first cycle after reset has no history, so no edge is reported then
	assign pin_edge = primed_reg ? (pins_now ^ pin_prev_reg) : 5'h00;
	assign detect_edge = pin_edge[3] | pin_edge[4];

	// event sources; detect edges are taken whatever card is present
	always_comb begin
		flag_set = 5'h00;
		sock_set = 4'h0;
		flag_set[`FLAG_BATTERY_ONE_BIT] = is_mem & pin_edge[0];
		flag_set[`FLAG_BATTERY_TWO_BIT] = is_mem & pin_edge[1];
		flag_set[`FLAG_READY_BIT]       = is_mem & pin_edge[2];
		// active low on io cards: only the fall from the released level counts, not a held low
		if (card_status_change_pin && pin_prev_reg[0] && primed_reg) begin
			flag_set[`FLAG_BATTERY_ONE_BIT] = 1'b1;
		end
		flag_set[`FLAG_POWER_DONE_BIT]  = power_up_done_in & (is_mem | is_io);
		flag_set[`FLAG_DETECT_BIT]      = detect_edge;
		sock_set[`SOCK_STATUS_BIT]      = cb_status_change_pin & ~pin_prev_reg[0] & primed_reg;
		sock_set[`SOCK_DETECT_ONE_BIT]  = pin_edge[3];
		sock_set[`SOCK_DETECT_TWO_BIT]  = pin_edge[4];
		sock_set[`SOCK_POWER_DONE_BIT]  = power_up_done_in & is_cb;
	end

	// -------------------------------------------------------------------------
	// flags, masks and register port
	// -------------------------------------------------------------------------
	// sets always beat a clear in the same cycle so no event is dropped
	always_comb begin
		logic rd_flags, wr_flags;
		rd_flags = reg_read_in  && (reg_addr_in == `CHANGE_FLAGS_OFFSET);
		wr_flags = reg_write_in && (reg_addr_in == `CHANGE_FLAGS_OFFSET);
		flags_next = flags_reg;
		if (rd_flags && !flag_clear_method_in) begin
			flags_next = 5'h00;
		end
		if (wr_flags && flag_clear_method_in) begin
			flags_next = flags_reg & ~reg_wdata_in[4:0];
		end
		flags_next = flags_next | flag_set;
		masks_next = masks_reg;
		ctl_spare_next = ctl_spare_reg;
		if (reg_write_in && reg_addr_in == `CHANGE_MASKS_OFFSET) begin
			masks_next = reg_wdata_in;
		end
		if (reg_write_in && reg_addr_in == `CARD_CONTROL_OFFSET) begin
			ctl_spare_next = reg_wdata_in[`CTL_SPARE_BIT];
		end
		// functional flag follows the card request; memory cards never raise it
		func_flag_next = io_card_irq_pin | cb_irq_pin;
		sock_event_next = (sock_event_reg & ~socket_event_clear_in) | sock_set;
		pin_prev_next = pins_now;
		primed_next = 1'b1;
		rdata_next = rdata_reg;
		if (reg_read_in) begin
			unique case (reg_addr_in)
				`CHANGE_FLAGS_OFFSET: rdata_next = {3'h0, flags_reg};
				`CHANGE_MASKS_OFFSET: rdata_next = masks_reg;
				`CARD_CONTROL_OFFSET: rdata_next = {ctl_spare_reg, 6'h00, func_flag_reg};
				default:              rdata_next = 8'h00;
			endcase
		end
	end

	// -------------------------------------------------------------------------
	// request generation and terminal routing
	// -------------------------------------------------------------------------
	// status change needs flag and enable; functional has no enable at all
	assign csc_req  = |(flags_reg & masks_reg[4:0]) | |(sock_event_reg & socket_mask_in);
	assign func_req = func_flag_reg;

	// terminal 0 is the open-drain pci line; 1..6 carry isa levels or the serial feed
	always_comb begin
		logic inta;
		inta = pci_intr_enable_in & (csc_req | (func_req && func_route_in == 3'h0));
		mf_out_next = 7'h00;
		mf_oe_next  = 7'h00;
		mf_oe_next[0] = inta;
		unique case (irq_scheme_in)
			card_socket_irq_pkg::SCHEME_PARALLEL: begin
				mf_out_next = route_onehot(csc_route_in, csc_req) |
					route_onehot(func_route_in, func_req);
				mf_oe_next = mf_oe_next | route_onehot(csc_route_in, 1'b1) |
					route_onehot(func_route_in, 1'b1);
			end
			card_socket_irq_pkg::SCHEME_SERIAL: begin
				// the serial framer samples terminal 6 as an active-low request level
				mf_out_next[6] = ~(csc_req | func_req);
				mf_oe_next[6]  = 1'b1;
			end
		endcase
		mf_out_next[0] = 1'b0;
		csc_next = csc_req;
	end

	// -------------------------------------------------------------------------
	// registers
	// -------------------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			flags_reg      <= `CHANGE_FLAGS_RESET;
			masks_reg      <= `CHANGE_MASKS_RESET;
			ctl_spare_reg  <= 1'b0;
			func_flag_reg  <= 1'b0;
			sock_event_reg <= `SOCK_EVENT_RESET;
			pin_prev_reg   <= 5'h00;
			primed_reg     <= 1'b0;
			rdata_reg      <= `READ_DATA_RESET;
			mf_out_reg     <= 7'h00;
			mf_oe_reg      <= 7'h00;
			csc_reg        <= 1'b0;
		end else begin
			flags_reg      <= flags_next;
			masks_reg      <= masks_next;
			ctl_spare_reg  <= ctl_spare_next;
			func_flag_reg  <= func_flag_next;
			sock_event_reg <= sock_event_next;
			pin_prev_reg   <= pin_prev_next;
			primed_reg     <= primed_next;
			rdata_reg      <= rdata_next;
			mf_out_reg     <= mf_out_next;
			mf_oe_reg      <= mf_oe_next;
			csc_reg        <= csc_next;
		end
	end

	assign reg_rdata_out             = rdata_reg;
	assign socket_event_out          = sock_event_reg;
	assign multifunction_outputs_out = mf_out_reg;
	assign multifunction_oe_out      = mf_oe_reg;
	assign status_change_event_out   = csc_reg;

	// -------------------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------------------
	a_ready_edge_flag: assert property (@(posedge clk_in) disable iff (rst_in)
		is_mem && pin_edge[2] |=> flags_reg[`FLAG_READY_BIT])
		else $error("ready edge not flagged");
	a_battery_edge_flag: assert property (@(posedge clk_in) disable iff (rst_in)
		is_mem && pin_edge[1] |=> flags_reg[`FLAG_BATTERY_TWO_BIT])
		else $error("battery edge not flagged");
	a_io_status_flag: assert property (@(posedge clk_in) disable iff (rst_in)
		primed_reg && is_io && $fell(battery_detect_one_in) |=> flags_reg[`FLAG_BATTERY_ONE_BIT])
		else $error("io status change not flagged");
	a_mem_no_func: assert property (@(posedge clk_in) disable iff (rst_in)
		is_mem |=> !func_flag_reg)
		else $error("functional flag with memory card");
	a_func_follows: assert property (@(posedge clk_in) disable iff (rst_in)
		(is_io || is_cb) && !ready_pin_in |=> func_flag_reg)
		else $error("functional request not flagged");
	a_detect_any_card: assert property (@(posedge clk_in) disable iff (rst_in)
		detect_edge |=> sock_event_reg[2:1] != 2'b00 && flags_reg[`FLAG_DETECT_BIT])
		else $error("detect edge lost");
	a_power_done_cb: assert property (@(posedge clk_in) disable iff (rst_in)
		power_up_done_in && is_cb |=> sock_event_reg[`SOCK_POWER_DONE_BIT])
		else $error("power done not recorded");
	a_read_clear: assert property (@(posedge clk_in) disable iff (rst_in)
		reg_read_in && reg_addr_in == `CHANGE_FLAGS_OFFSET && !flag_clear_method_in && flag_set == 5'h00
		|=> flags_reg == 5'h00 && reg_rdata_out == {3'h0, $past(flags_reg)})
		else $error("read did not clear flags");
	a_event_w1c: assert property (@(posedge clk_in) disable iff (rst_in)
		socket_event_clear_in[0] && !sock_set[0] |=> !sock_event_reg[0])
		else $error("socket event not cleared");
	a_csc_gate: assert property (@(posedge clk_in) disable iff (rst_in)
		(masks_reg[4:0] == 5'h00 && socket_mask_in == 4'h0) |=> !status_change_event_out)
		else $error("masked status change reported");

endmodule : card_socket_interrupt_events

// ### socket_card_model.sv
// far-side model: the inserted card on the shared socket pins, plus the pull-up on the pci line
// assumes: toggle requests are one cycle wide and change just after clk_in rises
`timescale 1ns/100ps

module socket_card_model (
	// clock and card state
	input  wire                                clk_in,
	input  card_socket_irq_pkg::card_type_type card_type_in,
	// toggle requests: bit0 bd1, bit1 bd2, bit2 ready, bit3 cd1, bit4 cd2
	input  wire  [4:0]                         toggle_in,
	// open-drain pci terminal
	input  wire                                pci_out_in,
	input  wire                                pci_oe_in,
	// socket pins and wired pci line
	output logic [4:0]                         pins_out = 5'h00,
	output wire                                pci_line_n_out
);
	card_socket_irq_pkg::card_type_type type_seen = card_socket_irq_pkg::CARD_NONE;

	// a fresh card releases its active-low pins high, so no false assertion at insertion
	always @(posedge clk_in) begin
		type_seen <= card_type_in;
		if (card_type_in !== type_seen) begin
			pins_out[0] <= (card_type_in === card_socket_irq_pkg::CARD_IO16);
			pins_out[2] <= (card_type_in === card_socket_irq_pkg::CARD_IO16) ||
				(card_type_in === card_socket_irq_pkg::CARD_CARDBUS);
		end else begin
			pins_out <= pins_out ^ toggle_in;
		end
	end

	// pull-up: a released line reads high
	assign pci_line_n_out = (pci_oe_in === 1'b1) ? pci_out_in : 1'b1;
endmodule : socket_card_model

// ### tb.sv
// self-checking bench for the socket interrupt event block
// assumes: the card model drives the socket pins; the bench drives registers and routing
`timescale 1ns/100ps

module tb;
	logic                                clk_in = 1'b0;
	logic                                rst_in = 1'b1;
	card_socket_irq_pkg::card_type_type  card_type = card_socket_irq_pkg::CARD_NONE;
	card_socket_irq_pkg::irq_scheme_type scheme = card_socket_irq_pkg::SCHEME_PARALLEL;
	logic [4:0]                          toggle = 5'h00;
	logic [4:0]                          pins;
	logic                                pwr = 1'b0, rd_s = 1'b0, wr_s = 1'b0, method = 1'b0, pci_line_n;
	logic                                pci_en = 1'b1;
	logic [7:0]                          addr = 8'h00, wdata = 8'h00, rdata;
	logic [3:0]                          smask = 4'h0, sclr = 4'h0, sevent;
	logic [2:0]                          csc_route = 3'h2, func_route = 3'h0;
	logic [6:0]                          mfo, moe;
	logic                                sce;
	int                                  num_errors = 0, tests_run = 0, cycles = 0;

	card_socket_interrupt_events i_card_socket_interrupt_events (.clk_in(clk_in), .rst_in(rst_in),
		.card_type_in(card_type), .battery_detect_one_in(pins[0]), .battery_detect_two_in(pins[1]),
		.ready_pin_in(pins[2]), .card_detect_one_in(pins[3]), .card_detect_two_in(pins[4]),
		.power_up_done_in(pwr), .reg_addr_in(addr), .reg_write_in(wr_s), .reg_read_in(rd_s),
		.reg_wdata_in(wdata), .reg_rdata_out(rdata), .socket_mask_in(smask), .socket_event_clear_in(sclr),
		.socket_event_out(sevent), .flag_clear_method_in(method), .pci_intr_enable_in(pci_en),
		.irq_scheme_in(scheme), .csc_route_in(csc_route), .func_route_in(func_route),
		.multifunction_outputs_out(mfo), .multifunction_oe_out(moe), .status_change_event_out(sce));

	socket_card_model i_socket_card_model (.clk_in(clk_in), .card_type_in(card_type), .toggle_in(toggle),
		.pci_out_in(mfo[0]), .pci_oe_in(moe[0]), .pins_out(pins), .pci_line_n_out(pci_line_n));

	// ----------------------------------------------------------------------
	// clock, timeout and shared tasks
	// ----------------------------------------------------------------------
	always #20 clk_in = ~clk_in;

	// a hang counts as a mismatch and still reaches the report
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			give_verdict();
		end
	end

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check

	// one-cycle strobe; rdata is settled just after the taking edge
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1 addr = a; wdata = d; wr_s = wr; rd_s = !wr;
		@(posedge clk_in);
		#1 wr_s = 1'b0; rd_s = 1'b0;
	endtask : access

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		access(1'b0, a, 8'h00);
		check(what, exp, rdata);
	endtask : rd

	// one-cycle pin toggles, power-done and socket clear pulses, then let the flags settle
	task automatic pulse(input logic [4:0] t, input logic p, input logic [3:0] c);
		@(posedge clk_in);
		#1 toggle = t; pwr = p; sclr = c;
		@(posedge clk_in);
		#1 toggle = 5'h00; pwr = 1'b0; sclr = 4'h0;
		repeat (4) @(posedge clk_in);
		#1;
	endtask : pulse

	task automatic give_verdict;
		$display("errors %0d, comparisons %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	// ----------------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk_in);
		#1 rst_in = 1'b0;
		rd(8'h04, 8'h00, "flags reset");
		rd(8'h05, 8'h00, "masks reset");
		rd(8'h91, 8'h00, "control reset");
		rd(8'h10, 8'h00, "unmapped");
		access(1'b1, 8'h05, 8'h1F);
		rd(8'h05, 8'h1F, "masks rw");
		// memory card: battery and ready edges, never a functional request
		card_type = card_socket_irq_pkg::CARD_MEM16;
		pulse(5'h01, 1'b0, 4'h0);
		check("csc request", 8'h01, {7'h00, sce});
		check("csc terminal", 8'h01, {7'h00, mfo[2]});
		pulse(5'h06, 1'b0, 4'h0);
		rd(8'h91, 8'h00, "mem func flag");
		rd(8'h04, 8'h07, "mem flags");
		rd(8'h04, 8'h00, "clear on read");
		pulse(5'h00, 1'b1, 4'h0);
		rd(8'h04, 8'h08, "power done");
		// masked detect edge flags without a request
		access(1'b1, 8'h05, 8'h00);
		pulse(5'h08, 1'b0, 4'h0);
		check("masked request", 8'h00, {7'h00, sce});
		rd(8'h04, 8'h10, "detect flag");
		// the socket event is recorded with a memory card too, and stays until cleared
		check("mem detect event", 8'h02, {4'h0, sevent});
		access(1'b1, 8'h05, 8'h1F);
		// write-one-clear method
		method = 1'b1;
		pulse(5'h04, 1'b0, 4'h0);
		rd(8'h04, 8'h04, "w1c read one");
		rd(8'h04, 8'h04, "w1c read kept");
		access(1'b1, 8'h04, 8'h04);
		rd(8'h04, 8'h00, "w1c cleared");
		method = 1'b0;
		// io card: status change on assertion only, functional request unmasked
		card_type = card_socket_irq_pkg::CARD_IO16;
		pulse(5'h00, 1'b0, 4'h0);
		rd(8'h04, 8'h00, "io insert");
		pulse(5'h01, 1'b0, 4'h0);
		rd(8'h04, 8'h01, "io status");
		pulse(5'h01, 1'b0, 4'h0);
		rd(8'h04, 8'h00, "io deassert");
		pulse(5'h04, 1'b0, 4'h0);
		rd(8'h91, 8'h01, "io func flag");
		check("pci line", 8'h00, {7'h00, pci_line_n});
		// pci line switched off: the pull-up must leave the line released
		pci_en = 1'b0;
		pulse(5'h00, 1'b0, 4'h0);
		check("pci disabled", 8'h01, {7'h00, pci_line_n});
		pci_en = 1'b1;
		func_route = 3'h3;
		pulse(5'h00, 1'b0, 4'h0);
		check("func terminal", 8'h01, {7'h00, mfo[3]});
		check("func enables", 8'h0C, {1'b0, moe});
		func_route = 3'h0;
		pulse(5'h04, 1'b0, 4'h0);
		rd(8'h91, 8'h00, "io func off");
		access(1'b1, 8'h91, 8'h81);
		rd(8'h91, 8'h80, "control ro bit");
		// cardbus: socket events, write-one clear
		card_type = card_socket_irq_pkg::CARD_CARDBUS;
		smask = 4'hF;
		// insertion raises no event; the clear drops the detect event held from the memory card
		pulse(5'h00, 1'b0, 4'hF);
		check("cb insert", 8'h00, {4'h0, sevent});
		pulse(5'h01, 1'b0, 4'h0);
		check("cb status", 8'h01, {4'h0, sevent});
		check("cb request", 8'h01, {7'h00, sce});
		pulse(5'h00, 1'b0, 4'h1);
		check("cb clear", 8'h00, {4'h0, sevent});
		pulse(5'h01, 1'b0, 4'h0);
		check("cb deassert", 8'h00, {4'h0, sevent});
		pulse(5'h04, 1'b0, 4'h0);
		rd(8'h91, 8'h81, "cb func flag");
		pulse(5'h04, 1'b0, 4'h0);
		pulse(5'h10, 1'b0, 4'h0);
		check("cb detect", 8'h04, {4'h0, sevent});
		pulse(5'h00, 1'b1, 4'h0);
		check("cb power", 8'h0C, {4'h0, sevent});
		// the legacy detect flag is set as well; power done stays out of the legacy flags
		rd(8'h04, 8'h10, "cb legacy flags");
		pulse(5'h00, 1'b0, 4'hF);
		// serial scheme: terminal 6 carries the combined request, active low
		scheme = card_socket_irq_pkg::SCHEME_SERIAL;
		pulse(5'h00, 1'b0, 4'h0);
		check("serial idle", 8'h01, {7'h00, mfo[6]});
		check("serial enables", 8'h40, {1'b0, moe});
		pulse(5'h08, 1'b0, 4'h0);
		check("cb detect one", 8'h02, {4'h0, sevent});
		check("serial request", 8'h00, {7'h00, mfo[6]});
		give_verdict();
	end
endmodule : tb
